// [rtl/cfgrsp_pkg.sv]
/*
 * Shared constants and types of the configuration message responder.
 * Assumes tokens arrive as 8-bit symbols with a control flag.
 */
package cfgrsp_pkg;
    // Control token codes
    localparam logic [7:0] TOK_WRITE = 8'hc0;
    localparam logic [7:0] TOK_READ = 8'hc1;
    localparam logic [7:0] TOK_END = 8'h01;
    localparam logic [7:0] TOK_ACK = 8'h03;
    localparam logic [7:0] TOK_NAK = 8'h04;
    // Low byte of a response identifier that asks for no reply to a write
    localparam logic [7:0] NO_REPLY_LOW = 8'hff;
    // Field lengths in bytes, counted from zero where used as a last index
    localparam logic [2:0] RSP_LAST = 3'h2;
    localparam logic [2:0] REG_LAST = 3'h1;
    localparam logic [2:0] WORD_LAST = 3'h3;
    // Reply byte positions
    localparam logic [3:0] IDX_STATUS = 4'h3;
    localparam logic [3:0] IDX_DATA = 4'h4;
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic ctrl;
        logic [7:0] data;
    } cfgrsp_tok_t;

    typedef struct packed {
        logic wr;
        logic byte_wide;
        logic [15:0] regnum;
        logic [31:0] wdata;
    } cfgrsp_acc_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RSP = 7'h02,
        ST_REG = 7'h04,
        ST_DATA = 7'h08,
        ST_END = 7'h10,
        ST_ACC = 7'h20,
        ST_REPLY = 7'h40
    } cfgrsp_state_t;
endpackage : cfgrsp_pkg

// [rtl/cfgrsp_responder.sv]
/*
 * Configuration register message responder and its reply token FIFO.
 * Assumes token streams and the register back end share clk_i; the back
 * end answers each held request with a one-cycle acc_done_i.
 */
// Function
// R1 - Request carries 24-bit reply channel-end
// R2 - Low byte all ones suppresses write reply
// R3 - Multi-byte fields go most significant first
// R4 - Status id is register shl 8 or 0x0B
// R5 - Status access moves one full 32-bit word
// R6 - Write: 192, id, reg, data, 1
// R7 - Read: 193, id, reg, 1
// R8 - Tile write answers 3,1 or 4,1
// R9 - Tile read answers 3,data,1 or 4,1
// R10 - Node target uses identical formats and replies
// R11 - Tile target addressed by tile id destination
// R12 - Node target addressed by node id destination
// R13 - Peripheral addressed by node, peripheral, 02
// R14 - Peripheral write answers 3,1 or 4,1
// R15 - Peripheral read returns 8 or 32 bits
// R16 - Bad lead or close token fails
`timescale 1ns/1ps

module cfgrsp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = cfgrsp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two for the wrapping pointers
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("cfgrsp_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);

    // Status and data seen by both sides
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr_r[AW-1:0]];

    // Storage array
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    // Pointer update
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
            rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
        end
    end
endmodule : cfgrsp_fifo

module cfgrsp_responder #(
    parameter int FIFO_DEPTH = cfgrsp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Request token stream
    input wire logic in_valid_i,
    input wire cfgrsp_pkg::cfgrsp_tok_t in_tok_i,
    output logic in_ready_o,
    input wire logic byte_wide_i, // Peripheral 8-bit access, sampled at lead token
    // Reply token stream, header bytes first
    output logic out_valid_o,
    output cfgrsp_pkg::cfgrsp_tok_t out_tok_o,
    input wire logic out_ready_i,
    // Register back end
    output logic acc_req_o,
    output cfgrsp_pkg::cfgrsp_acc_t acc_o,
    input wire logic acc_done_i,
    input wire logic acc_ok_i,
    input wire logic [31:0] acc_rdata_i
);
    cfgrsp_pkg::cfgrsp_state_t state_r, state_nxt;
    logic [23:0] rsp_r;
    logic [15:0] reg_r;
    logic [31:0] data_r;
    logic [2:0] cnt_r;
    logic [3:0] idx_r;
    logic wr_r, bw_r, ok_r;
    cfgrsp_pkg::cfgrsp_tok_t push_tok;
    logic push_rdy;

    // Build one reply token; header and data are sent high byte first
    function automatic cfgrsp_pkg::cfgrsp_tok_t reply_tok(input logic [3:0] idx, input logic [3:0] last,
                                                          input logic ok, input logic [2:0] dlast,
                                                          input logic [23:0] rsp, input logic [31:0] dat);
        logic [2:0] k;
        k = 3'(idx - cfgrsp_pkg::IDX_DATA);
        if (idx < cfgrsp_pkg::IDX_STATUS) begin
            reply_tok = {1'b0, 8'(rsp >> (5'd8 * 5'(cfgrsp_pkg::RSP_LAST - 3'(idx))))};
        end else if (idx == cfgrsp_pkg::IDX_STATUS) begin
            reply_tok = {1'b1, ok ? cfgrsp_pkg::TOK_ACK : cfgrsp_pkg::TOK_NAK};
        end else if (idx == last) begin
            reply_tok = {1'b1, cfgrsp_pkg::TOK_END};
        end else begin
            reply_tok = {1'b0, 8'(dat >> (6'd8 * 6'(dlast - k)))};
        end
    endfunction : reply_tok

    // Decode of the incoming token and reply shape
    wire fire = in_valid_i && in_ready_o;
    wire is_ctrl = in_tok_i.ctrl;
    wire is_lead = is_ctrl && (in_tok_i.data == cfgrsp_pkg::TOK_WRITE || in_tok_i.data == cfgrsp_pkg::TOK_READ);
    wire is_close = is_ctrl && (in_tok_i.data == cfgrsp_pkg::TOK_END);
    wire [2:0] dlast = bw_r ? 3'h0 : cfgrsp_pkg::WORD_LAST;
    wire with_data = !wr_r && ok_r;
    wire [3:0] last_idx = cfgrsp_pkg::IDX_DATA + (with_data ? 4'(dlast) + 4'h1 : 4'h0);
    wire suppress = wr_r && (rsp_r[7:0] == cfgrsp_pkg::NO_REPLY_LOW);
    wire push = (state_r == cfgrsp_pkg::ST_REPLY) && !suppress && push_rdy;
    wire push_last = push && (idx_r == last_idx);

    assign in_ready_o = (state_r != cfgrsp_pkg::ST_ACC) && (state_r != cfgrsp_pkg::ST_REPLY);
    assign push_tok = reply_tok(idx_r, last_idx, ok_r, dlast, rsp_r, data_r);
    assign acc_req_o = (state_r == cfgrsp_pkg::ST_ACC);
    assign acc_o = '{wr: wr_r, byte_wide: bw_r, regnum: reg_r, wdata: data_r};

    // Message parser and reply sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cfgrsp_pkg::ST_IDLE: begin
                // R16 unknown lead fails
                if (fire && is_ctrl && !is_close) begin
                    state_nxt = is_lead ? cfgrsp_pkg::ST_RSP : cfgrsp_pkg::ST_REPLY;
                end
            end
            cfgrsp_pkg::ST_RSP: begin
                if (fire && is_ctrl) begin
                    state_nxt = cfgrsp_pkg::ST_REPLY;
                end else if (fire && cnt_r == cfgrsp_pkg::RSP_LAST) begin
                    state_nxt = cfgrsp_pkg::ST_REG;
                end
            end
            cfgrsp_pkg::ST_REG: begin
                if (fire && is_ctrl) begin
                    state_nxt = cfgrsp_pkg::ST_REPLY;
                end else if (fire && cnt_r == cfgrsp_pkg::REG_LAST) begin
                    state_nxt = wr_r ? cfgrsp_pkg::ST_DATA : cfgrsp_pkg::ST_END;
                end
            end
            cfgrsp_pkg::ST_DATA: begin
                if (fire && is_ctrl) begin
                    state_nxt = cfgrsp_pkg::ST_REPLY;
                end else if (fire && cnt_r == dlast) begin
                    state_nxt = cfgrsp_pkg::ST_END;
                end
            end
            cfgrsp_pkg::ST_END: begin
                // R16 missing close fails
                if (fire) begin
                    state_nxt = is_close ? cfgrsp_pkg::ST_ACC : cfgrsp_pkg::ST_REPLY;
                end
            end
            cfgrsp_pkg::ST_ACC: begin
                if (acc_done_i) begin
                    state_nxt = cfgrsp_pkg::ST_REPLY;
                end
            end
            cfgrsp_pkg::ST_REPLY: begin
                // R2 suppressed write reply
                if (suppress || push_last) begin
                    state_nxt = cfgrsp_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = cfgrsp_pkg::ST_IDLE;
            end
        endcase
    end

    // State and field capture
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= cfgrsp_pkg::ST_IDLE;
            {rsp_r, reg_r, data_r} <= '0;
            {cnt_r, idx_r, wr_r, bw_r, ok_r} <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= (state_nxt != state_r) ? 3'h0 : cnt_r + 3'(fire);
            idx_r <= (state_r != cfgrsp_pkg::ST_REPLY) ? 4'h0 : idx_r + 4'(push);
            if (state_r == cfgrsp_pkg::ST_IDLE && fire) begin
                wr_r <= in_tok_i.data == cfgrsp_pkg::TOK_WRITE;
                bw_r <= byte_wide_i;
                ok_r <= 1'b0;
                data_r <= '0; // Byte writes leave no stale upper bytes
                rsp_r <= '0; // Unknown lead: no identifier to answer
            end
            // R1 R3 reply identifier, high byte first
            if (state_r == cfgrsp_pkg::ST_RSP && fire) begin
                rsp_r <= {rsp_r[15:0], in_tok_i.data};
            end
            // R6 R7 register number, high byte first
            if (state_r == cfgrsp_pkg::ST_REG && fire) begin
                reg_r <= {reg_r[7:0], in_tok_i.data};
            end
            if (state_r == cfgrsp_pkg::ST_DATA && fire) begin
                data_r <= {data_r[23:0], in_tok_i.data};
            end
            // R5 R15 word or byte read data
            if (state_r == cfgrsp_pkg::ST_ACC && acc_done_i) begin
                ok_r <= acc_ok_i;
                data_r <= bw_r ? {24'h0, acc_rdata_i[7:0]} : acc_rdata_i;
            end
        end
    end

    // Reply tokens queue ahead of the interconnect
    cfgrsp_fifo #(
        .WIDTH($bits(cfgrsp_pkg::cfgrsp_tok_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_data_i(push_tok),
        .in_ready_o(push_rdy),
        .out_valid_o(out_valid_o),
        .out_data_o(out_tok_o),
        .out_ready_i(out_ready_i)
    );

    // Checks of reply content and sequencing
    sequence s_close;
        state_r == cfgrsp_pkg::ST_END && fire && is_close;
    endsequence
    sequence s_bad_close;
        state_r == cfgrsp_pkg::ST_END && fire && !is_close;
    endsequence

    chk_hdr_msb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        push && idx_r == 4'h0 |-> push_tok == {1'b0, rsp_r[23:16]})
        else $error("reply header not high byte first");
    chk_status_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        push && idx_r == cfgrsp_pkg::IDX_STATUS && ok_r |-> push_tok == {1'b1, cfgrsp_pkg::TOK_ACK})
        else $error("success status token wrong");
    chk_status_nak: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
        push && idx_r == cfgrsp_pkg::IDX_STATUS && !ok_r |-> push_tok == {1'b1, cfgrsp_pkg::TOK_NAK})
        else $error("failure status token wrong");
    chk_last_end: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
        push_last |-> push_tok == {1'b1, cfgrsp_pkg::TOK_END} ##1 state_r == cfgrsp_pkg::ST_IDLE)
        else $error("reply not closed by end token");
    chk_suppress_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
        state_r == cfgrsp_pkg::ST_REPLY && suppress |-> !push ##1 state_r == cfgrsp_pkg::ST_IDLE)
        else $error("suppressed reply was sent");
    chk_close_access: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
        s_close |=> acc_req_o && acc_o.regnum == $past(reg_r, 1))
        else $error("closed request not issued");
    chk_bad_close: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
        s_bad_close |=> state_r == cfgrsp_pkg::ST_REPLY && !ok_r && !acc_req_o)
        else $error("unclosed request not failed");
    chk_byte_read_len: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
        state_r == cfgrsp_pkg::ST_REPLY && !wr_r && ok_r |-> last_idx == (bw_r ? 4'h5 : 4'h8))
        else $error("read reply length wrong");
    chk_word_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
        state_r == cfgrsp_pkg::ST_ACC && acc_done_i && !bw_r |=> data_r == $past(acc_rdata_i))
        else $error("read word not captured whole");

    // Failure paths, held access and reply body
    chk_lead_unknown: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
        state_r == cfgrsp_pkg::ST_IDLE && fire && is_ctrl && !is_lead && !is_close
        |=> state_r == cfgrsp_pkg::ST_REPLY && rsp_r == 24'h0 && !ok_r)
        else $error("unknown lead token not failed");
    chk_ctrl_midfield: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
        (state_r == cfgrsp_pkg::ST_RSP || state_r == cfgrsp_pkg::ST_REG || state_r == cfgrsp_pkg::ST_DATA)
        && fire && is_ctrl |=> state_r == cfgrsp_pkg::ST_REPLY && !ok_r && !acc_req_o)
        else $error("control token inside a field not failed");
    chk_acc_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
        acc_req_o && !acc_done_i |=> acc_req_o && $stable(acc_o))
        else $error("access request dropped or changed early");
    chk_word_msb: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
        push && idx_r == cfgrsp_pkg::IDX_DATA && !wr_r && ok_r && !bw_r |-> push_tok == {1'b0, data_r[31:24]})
        else $error("read word not high byte first");
    chk_byte_data: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
        push && idx_r == cfgrsp_pkg::IDX_DATA && !wr_r && ok_r && bw_r |-> push_tok == {1'b0, data_r[7:0]})
        else $error("byte read data token wrong");
    chk_write_nodata: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        push && idx_r == cfgrsp_pkg::IDX_DATA && wr_r |-> push_tok == {1'b1, cfgrsp_pkg::TOK_END})
        else $error("write reply carries data");
endmodule : cfgrsp_responder

// [verification/cfgrsp_req_model.sv]
/* Requesting channel-end model: sends request token messages, drains replies.
   Assumes the responder shares clk_i and takes a token on valid and ready. */
`timescale 1ns/1ps
module cfgrsp_req_model (
    // Clock
    input wire logic clk_i,
    // Request stream
    output logic valid_o,
    output cfgrsp_pkg::cfgrsp_tok_t tok_o,
    input wire logic ready_i,
    // Reply stream
    input wire logic slow_i,
    output logic out_ready_o
);
    logic [2:0] cnt_r = 3'h0;
    logic [31:0] dest_r = 32'h0;
    // destination word of each target kind
    function automatic logic [31:0] dest_of(input logic [1:0] kind, input logic [15:0] id, input logic [7:0] sub);
        case (kind)
            2'h0: dest_of = {8'h00, id, 8'h0b};
            2'h1: dest_of = {id, 16'hc20c};
            2'h2: dest_of = {id, 16'hc30c};
            default: dest_of = {id, sub, 8'h02};
        endcase
    endfunction : dest_of
    initial begin
        valid_o = 1'b0;
        tok_o = 9'h1aa;
        out_ready_o = 1'b0;
    end
    // Drains at once, or stalls seven cycles in eight
    always @(posedge clk_i) begin
        cnt_r <= cnt_r + 3'h1;
        out_ready_o <= !slow_i || (cnt_r == 3'h0);
    end
    // Holds one token until taken
    task automatic put(input logic c, input logic [7:0] d);
        valid_o <= 1'b1;
        tok_o <= {c, d};
        do @(posedge clk_i); while (!ready_i);
    endtask : put
    task automatic send(input logic [7:0] lead, input logic [23:0] rsp, input logic [15:0] rn,
                        input logic [31:0] d, input int nd, input logic [7:0] close);
        @(posedge clk_i);
        dest_r <= dest_of(rn[9:8], 16'h0001, rn[7:0]); // Target node one
        put(1'b1, lead);
        if (nd >= 0) begin
            for (int i = 2; i >= 0; i--) put(1'b0, rsp[i*8+:8]);
            for (int i = 1; i >= 0; i--) put(1'b0, rn[i*8+:8]);
            for (int i = nd - 1; i >= 0; i--) put(1'b0, d[i*8+:8]);
            put(1'b1, close);
        end
        // Released stream shows a changing pattern
        valid_o <= 1'b0;
        tok_o <= ~tok_o;
    endtask : send
endmodule : cfgrsp_req_model

// [verification/tb.sv]
/* Self-checking bench of the configuration message responder.
   Assumes the requester model and a register back end with random latency. */
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic in_valid, in_ready, out_valid, out_ready, acc_req;
    logic byte_wide = 1'b0, slow = 1'b0, acc_done = 1'b0, acc_ok = 1'b0;
    cfgrsp_pkg::cfgrsp_tok_t in_tok, out_tok;
    cfgrsp_pkg::cfgrsp_acc_t acc;
    logic [31:0] acc_rdata = 32'h0, seed = 32'h62736cf0;
    logic [31:0] mem [16];
    logic [31:0] shadow [16];
    logic [8:0] exp_q [$];
    logic [8:0] acc_q [$];
    logic [2:0] lat = 3'h0;
    int bad_count = 0, checks = 0, cycles = 0;
    always #2 clk_i = ~clk_i;

    cfgrsp_req_model i_req (.clk_i(clk_i), .valid_o(in_valid), .tok_o(in_tok), .ready_i(in_ready),
        .slow_i(slow), .out_ready_o(out_ready));
    cfgrsp_responder i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_valid_i(in_valid), .in_tok_i(in_tok),
        .in_ready_o(in_ready), .byte_wide_i(byte_wide), .out_valid_o(out_valid), .out_tok_o(out_tok),
        .out_ready_i(out_ready), .acc_req_o(acc_req), .acc_o(acc), .acc_done_i(acc_done),
        .acc_ok_i(acc_ok), .acc_rdata_i(acc_rdata));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Notes the reply tokens a request should bring
    task automatic expect_reply(input logic [23:0] rsp, input logic ok, input logic wr, input int nd,
                                input logic [31:0] d);
        if (wr && rsp[7:0] == cfgrsp_pkg::NO_REPLY_LOW) return;
        for (int i = 2; i >= 0; i--) exp_q.push_back({1'b0, rsp[i*8+:8]});
        exp_q.push_back({1'b1, ok ? cfgrsp_pkg::TOK_ACK : cfgrsp_pkg::TOK_NAK});
        if (ok && !wr) for (int i = nd - 1; i >= 0; i--) exp_q.push_back({1'b0, d[i*8+:8]});
        exp_q.push_back({1'b1, cfgrsp_pkg::TOK_END});
    endtask : expect_reply
    // One request; a byte read passes its byte as d
    task automatic xfer(input logic wr, input logic [23:0] rsp, input logic [15:0] rn, input logic [31:0] d,
                        input logic bw, input logic [7:0] close);
        logic ok;
        ok = rn < 16'h0100 && close == cfgrsp_pkg::TOK_END;
        expect_reply(rsp, ok, wr, bw ? 1 : 4, (wr || bw) ? d : shadow[rn[3:0]]);
        if (wr && ok && !bw) shadow[rn[3:0]] = d;
        if (close == cfgrsp_pkg::TOK_END) acc_q.push_back({bw, rn[7:0]});
        byte_wide <= bw;
        i_req.send(wr ? cfgrsp_pkg::TOK_WRITE : cfgrsp_pkg::TOK_READ, rsp, rn, d, wr ? (bw ? 1 : 4) : 0, close);
    endtask : xfer

    // Register back end: random latency, numbers from 0x100 up fail
    always @(posedge clk_i) begin
        acc_done <= 1'b0;
        if (acc_req && !acc_done) begin
            lat <= lat - 3'h1;
            if (lat == 3'h0) begin
                check({acc.byte_wide, acc.regnum[7:0]}, acc_q.size() ? acc_q.pop_front() : 9'hxxx);
                acc_done <= 1'b1;
                acc_ok <= acc.regnum < 16'h0100;
                acc_rdata <= mem[acc.regnum[3:0]];
                if (acc.wr && acc.regnum < 16'h0100) mem[acc.regnum[3:0]] <= acc.wdata;
                lat <= seed[2:0];
            end
        end
    end
    // Compares each popped reply token with the oldest note
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
        if (rst_n_i && out_valid && out_ready) check(out_tok, exp_q.size() ? exp_q.pop_front() : 9'hxxx);
    end

    initial begin
        logic [31:0] r;
        foreach (mem[i]) begin
            mem[i] = 32'h0;
            shadow[i] = 32'h0;
        end
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        xfer(1'b1, 24'h123456, 16'h0005, 32'hcafe0123, 1'b0, cfgrsp_pkg::TOK_END);
        xfer(1'b0, 24'h123457, 16'h0005, 32'h0, 1'b0, cfgrsp_pkg::TOK_END);
        xfer(1'b1, 24'h00a1ff, 16'h0006, 32'h89abcdef, 1'b0, cfgrsp_pkg::TOK_END);
        xfer(1'b0, 24'h00a1fe, 16'h0006, 32'h0, 1'b0, cfgrsp_pkg::TOK_END);
        xfer(1'b1, 24'h7f0010, 16'h0200, 32'h11223344, 1'b0, cfgrsp_pkg::TOK_END);
        xfer(1'b0, 24'h7f0011, 16'hffff, 32'h0, 1'b0, cfgrsp_pkg::TOK_END);
        // wrong close token and wrong lead
        xfer(1'b1, 24'h450020, 16'h0001, 32'h5a5a5a5a, 1'b0, 8'h02);
        xfer(1'b1, 24'h4500ff, 16'h0001, 32'h5a5a5a5a, 1'b0, 8'h02);
        xfer(1'b0, 24'h450021, 16'h0001, 32'h0, 1'b0, cfgrsp_pkg::TOK_WRITE);
        expect_reply(24'h0, 1'b0, 1'b0, 4, 32'h0);
        i_req.send(8'h55, 24'h0, 16'h0, 32'h0, -1, 8'h0);
        // close token where write data is due
        expect_reply(24'h450022, 1'b0, 1'b1, 4, 32'h0);
        i_req.send(cfgrsp_pkg::TOK_WRITE, 24'h450022, 16'h0001, 32'h0, 0, cfgrsp_pkg::TOK_END);
        // random traffic with a stalling drain
        slow <= 1'b1;
        for (int n = 0; n < 24; n++) begin
            seed = xs(seed);
            r = seed;
            seed = xs(seed);
            xfer(r[0], r[31:8], {7'h0, r[1] & r[2], 4'h0, r[6:3]}, seed, 1'b0, cfgrsp_pkg::TOK_END);
        end
        xfer(1'b1, 24'h220033, 16'h0009, 32'h000000a5, 1'b1, cfgrsp_pkg::TOK_END);
        xfer(1'b0, 24'h220034, 16'h0009, 32'h000000a5, 1'b1, cfgrsp_pkg::TOK_END);
        repeat (3000) if (exp_q.size() != 0) @(posedge clk_i);
        repeat (20) @(posedge clk_i);
        // Replies or accesses still owed count as a hang
        if (exp_q.size() != 0 || acc_q.size() != 0) bad_count++;
        finish_test();
    end
endmodule : tb
